// ### core/fsc_consts.svh
// Holds the offsets, bit positions, masks and reset values of the fault status capture block.
// Assumes it is included by bare name from package and modules alike.
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// Register offsets in the system control space.
`define FSC_CTRL_OFS     12'hD24
`define FSC_FAULT_OFS    12'hD28
`define FSC_BUSB_OFS     12'hD29
`define FSC_USAGEH_OFS   12'hD2A

// Handler state control bit positions.
`define FSC_MEM_ACT_BIT  0
`define FSC_BUS_ACT_BIT  1

// Usage fault bit positions in the full word.
`define FSC_UNDECODABLE_INSTRUCTION_FLAG_BIT    16
`define FSC_BADSTATE_BIT 17
`define FSC_BADRET_BIT   18
`define FSC_MISSING_COPROCESSOR_FLAG_BIT     19
`define FSC_MISALIGN_BIT 24
`define FSC_DIVIDE_ZERO_FLAG_BIT     25

// Bus fault bit positions in the full word.
`define FSC_INSTRUCTION_BUS_ERROR_FLAG_BIT     8
`define FSC_PRECISE_BIT  9
`define FSC_IMPRECISE_BUS_ERROR_FLAG_BIT    10
`define FSC_UNSTK_BIT    11
`define FSC_STK_BIT      12
`define FSC_LAZYFP_BIT   13
`define FSC_BUS_ADDRESS_VALID_BIT    15

// Subfield bounds and implemented bit masks.
`define FSC_USAGE_LSB    16
`define FSC_BUS_LSB      8
`define FSC_USAGE_IMPL   16'h030F
`define FSC_BUS_IMPL     8'hBF

// Reset values.
`define FSC_FAULT_RST    32'h0000_0000
`define FSC_CTRL_RST     2'h0
`define FSC_RDATA_RST    32'h0000_0000

// Byte lane masks.
`define FSC_LANES_NONE   4'h0
`define FSC_LANES_B0     4'h1
`define FSC_LANES_B1     4'h2
`define FSC_LANES_LOWH   4'h3
`define FSC_LANES_HIGHH  4'hC
`define FSC_LANES_ALL    4'hF

`endif

// ### core/fsc_pkg.sv
// Holds the types shared by the fault status capture block.
// Assumes fsc_consts.svh sits beside it.
`include "fsc_consts.svh"

package fsc_pkg;

    // Width of an access on the register port.
    typedef enum logic [1:0] {
        FSC_SZ_BYTE,
        FSC_SZ_HALF,
        FSC_SZ_WORD
    } fsc_size_t;

    // One register port request.
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        fsc_size_t   size;
        logic        wr;
        logic        rd;
        logic        priv;
    } fsc_bus_req_t;

    // Fault events reported by the core, one-cycle pulses.
    typedef struct packed {
        logic divide_zero;
        logic misaligned;
        logic misaligned_multi;
        logic no_coproc;
        logic bad_return;
        logic bad_state;
        logic undecodable_instruction_flag_instr;
        logic bus_addr_known;
        logic mem_fault_later;
        logic stacking_err;
        logic unstacking_err;
        logic imprecise_err;
        logic precise_err;
        logic instr_bus_err;
        logic lazy_fp_err;
    } fsc_events_t;

    // Register state of the top module.
    typedef struct packed {
        logic [1:0]  active;
        logic [31:0] rdata;
        logic        err;
    } fsc_state_t;

endpackage

// ### core/fsc_w1c_field.sv
// Holds a sticky field of flags set by hardware and cleared by writing ones.
// Assumes set and clear masks are one-cycle, synchronous to clk.
`timescale 1ns/1ns

module fsc_w1c_field
    import fsc_pkg::*;
#(
    parameter int unsigned  W    = 8,
    parameter logic [W-1:0] IMPL = '1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] flags;
    } fsc_flags_t;

    fsc_flags_t st_q;
    fsc_flags_t st_d;

    // A set in the same cycle as a clear wins; unimplemented bits stay zero.
    always_comb begin
        st_d.flags = ((st_q.flags & ~clr) | set) & IMPL;
    end

    // Flags start at zero.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.flags;

endmodule

// ### core/fsc_access_decode.sv
// Decodes a register port request into a target and its byte lanes.
// Assumes the request is synchronous to clk and strobes are one cycle long.
`timescale 1ns/1ns
`include "fsc_consts.svh"

module fsc_access_decode
    import fsc_pkg::*;
(
    input  wire fsc_bus_req_t req,
    output logic              hit_fault,
    output logic              hit_ctrl,
    output logic              refused,
    output logic [3:0]        lanes
);
    // Only the listed width and offset pairs map; others and user-mode accesses are refused.
    always_comb begin
        hit_fault = 1'b0;
        hit_ctrl  = 1'b0;
        lanes     = `FSC_LANES_NONE;
        if (req.priv) begin
            case (req.size)
                FSC_SZ_WORD: begin
                    if (req.addr == `FSC_FAULT_OFS) begin
                        hit_fault = 1'b1;
                        lanes     = `FSC_LANES_ALL;
                    end else if (req.addr == `FSC_CTRL_OFS) begin
                        hit_ctrl = 1'b1;
                        lanes    = `FSC_LANES_ALL;
                    end
                end
                FSC_SZ_HALF: begin
                    hit_fault = (req.addr == `FSC_FAULT_OFS) || (req.addr == `FSC_USAGEH_OFS);
                    lanes     = (req.addr == `FSC_FAULT_OFS)  ? `FSC_LANES_LOWH :
                                (req.addr == `FSC_USAGEH_OFS) ? `FSC_LANES_HIGHH : `FSC_LANES_NONE;
                end
                FSC_SZ_BYTE: begin
                    hit_fault = (req.addr == `FSC_FAULT_OFS) || (req.addr == `FSC_BUSB_OFS);
                    lanes     = (req.addr == `FSC_FAULT_OFS) ? `FSC_LANES_B0 :
                                (req.addr == `FSC_BUSB_OFS)  ? `FSC_LANES_B1 : `FSC_LANES_NONE;
                end
                default: begin
                    lanes = `FSC_LANES_NONE;
                end
            endcase
        end
        refused = (req.wr || req.rd) && !hit_fault && !hit_ctrl;
    end

endmodule

// ### core/fsc_fault_status.sv
// Holds the fault status capture block: handler active flags and the sticky fault cause word.
// Assumes one clock, privileged status given per access, and trap enables driven by the core.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`include "fsc_consts.svh"

module fsc_fault_status
    import fsc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire fsc_bus_req_t req,
    input  wire fsc_events_t  ev,
    input  wire logic         div_trap_en,
    input  wire logic         misalign_trap_en,
    output logic       [31:0] rdata_q,
    output logic              err_q,
    output logic       [31:0] fault_status_q,
    output logic       [1:0]  active_q
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Access decode
    ////////////////////////////////////////////////////////////////////////////////////////////////

    logic        hit_fault;
    logic        hit_ctrl;
    logic        refused;
    logic [3:0]  lanes;
    logic [31:0] lane_mask;
    logic [31:0] sw_clr;
    logic [31:0] hw_set;
    logic [31:0] hw_clr;
    logic [31:0] status_w;
    logic [15:0] usage_q;
    logic [7:0]  bus_q;

    // Decoder resolves target, lanes and refusal of unmapped or user-mode accesses.
    fsc_access_decode u_decode (
        .req       (req),
        .hit_fault (hit_fault),
        .hit_ctrl  (hit_ctrl),
        .refused   (refused),
        .lanes     (lanes)
    );

    // Byte lanes widen into a bit mask.
    always_comb begin
        lane_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Fault cause capture
    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Ones written into the accessed lanes clear flags; zeros do nothing.
    always_comb begin
        sw_clr = (req.wr && hit_fault) ? (req.wdata & lane_mask) : 32'h0000_0000;
    end

    // Core events turn into set requests, gated by the trap enables where required.
    always_comb begin
        hw_set                    = 32'h0000_0000;
        hw_set[`FSC_DIVIDE_ZERO_FLAG_BIT]     = ev.divide_zero && div_trap_en;
        hw_set[`FSC_MISALIGN_BIT] = (ev.misaligned && misalign_trap_en) || ev.misaligned_multi;
        hw_set[`FSC_MISSING_COPROCESSOR_FLAG_BIT]     = ev.no_coproc;
        hw_set[`FSC_BADRET_BIT]   = ev.bad_return;
        hw_set[`FSC_BADSTATE_BIT] = ev.bad_state && !ev.undecodable_instruction_flag_instr;
        hw_set[`FSC_UNDECODABLE_INSTRUCTION_FLAG_BIT]    = ev.undecodable_instruction_flag_instr;
        hw_set[`FSC_BUS_ADDRESS_VALID_BIT]    = ev.bus_addr_known;
        hw_set[`FSC_LAZYFP_BIT]   = ev.lazy_fp_err;
        hw_set[`FSC_STK_BIT]      = ev.stacking_err;
        hw_set[`FSC_UNSTK_BIT]    = ev.unstacking_err;
        hw_set[`FSC_IMPRECISE_BUS_ERROR_FLAG_BIT]    = ev.imprecise_err;
        hw_set[`FSC_PRECISE_BIT]  = ev.precise_err;
        hw_set[`FSC_INSTRUCTION_BUS_ERROR_FLAG_BIT]     = ev.instr_bus_err;
    end

    // A later memory fault invalidates the captured bus fault address.
    always_comb begin
        hw_clr                 = sw_clr;
        hw_clr[`FSC_BUS_ADDRESS_VALID_BIT] = sw_clr[`FSC_BUS_ADDRESS_VALID_BIT] || ev.mem_fault_later;
    end

    // Usage subfield in the upper half.
    fsc_w1c_field #(
        .W    (16),
        .IMPL (`FSC_USAGE_IMPL)
    ) u_usage (
        .clk    (clk),
        .arst_n (arst_n),
        .set    (hw_set[31:16]),
        .clr    (hw_clr[31:16]),
        .q      (usage_q)
    );

    // Bus subfield in byte one.
    fsc_w1c_field #(
        .W    (8),
        .IMPL (`FSC_BUS_IMPL)
    ) u_bus (
        .clk    (clk),
        .arst_n (arst_n),
        .set    (hw_set[15:8]),
        .clr    (hw_clr[15:8]),
        .q      (bus_q)
    );

    // The memory subfield has no causes here and reads as zero.
    always_comb begin
        status_w = {usage_q, bus_q, 8'h00};
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Active flags and read port
    ////////////////////////////////////////////////////////////////////////////////////////////////

    fsc_state_t st_q;
    fsc_state_t st_d;

    // Next state: active flags on a control write, read data only in the cycle after a read.
    always_comb begin
        st_d       = st_q;
        st_d.rdata = `FSC_RDATA_RST;
        st_d.err   = refused;
        if (req.wr && hit_ctrl) begin
            st_d.active[`FSC_BUS_ACT_BIT] = req.wdata[`FSC_BUS_ACT_BIT];
            st_d.active[`FSC_MEM_ACT_BIT] = req.wdata[`FSC_MEM_ACT_BIT];
        end
        if (req.rd && hit_fault) begin
            st_d.rdata = status_w & lane_mask;
        end else if (req.rd && hit_ctrl) begin
            st_d.rdata = {30'h0000_0000, st_q.active};
        end
    end

    // State register with constant reset values.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q.active <= `FSC_CTRL_RST;
            st_q.rdata  <= `FSC_RDATA_RST;
            st_q.err    <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from flip-flops.
    assign rdata_q        = st_q.rdata;
    assign err_q          = st_q.err;
    assign active_q       = st_q.active;
    assign fault_status_q = status_w;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Memory byte never reports, reserved bits never set.
    chk_mem_byte_zero: assert property (fault_status_q[7:0] == 8'h00)
        else $error("memory fault byte is not zero");
    chk_reserved_bits_zero: assert property ((fault_status_q & ~{`FSC_USAGE_IMPL, `FSC_BUS_IMPL, 8'h00}) == 32'h0)
        else $error("reserved fault status bit set");

    // A flag other than bus address valid may fall only after a one was written to it.
    chk_sticky_undecodable_instruction_flag_bit: assert property ($fell(fault_status_q[`FSC_UNDECODABLE_INSTRUCTION_FLAG_BIT]) |-> $past(sw_clr[`FSC_UNDECODABLE_INSTRUCTION_FLAG_BIT]))
        else $error("undefined instruction flag fell without a clear");
    chk_sticky_stack_bit: assert property (
        fault_status_q[`FSC_STK_BIT] && !(req.wr && hit_fault && req.wdata[`FSC_STK_BIT] && lanes[1])
        |=> fault_status_q[`FSC_STK_BIT])
        else $error("stacking flag lost without a clear");

    // Event flags follow their cause one cycle later, even against a clear.
    chk_div_zero_set: assert property (ev.divide_zero && div_trap_en |=> fault_status_q[`FSC_DIVIDE_ZERO_FLAG_BIT])
        else $error("divide by zero not flagged");
    chk_div_zero_gate: assert property (!(ev.divide_zero && div_trap_en) |=> !$rose(fault_status_q[`FSC_DIVIDE_ZERO_FLAG_BIT]))
        else $error("divide by zero flagged while untrapped");
    chk_misalign_multi: assert property (ev.misaligned_multi |=> fault_status_q[`FSC_MISALIGN_BIT])
        else $error("multiple word misalign not flagged");
    chk_misalign_gate: assert property (
        !ev.misaligned_multi && !(ev.misaligned && misalign_trap_en) |=> !$rose(fault_status_q[`FSC_MISALIGN_BIT]))
        else $error("misalign flagged while untrapped");
    chk_missing_coprocessor_flag_set: assert property (ev.no_coproc |=> fault_status_q[`FSC_MISSING_COPROCESSOR_FLAG_BIT])
        else $error("coprocessor access not flagged");
    chk_bad_return_set: assert property (ev.bad_return |=> fault_status_q[`FSC_BADRET_BIT])
        else $error("bad return load not flagged");
    chk_bad_state_set: assert property (
        ev.bad_state && !ev.undecodable_instruction_flag_instr |=> fault_status_q[`FSC_BADSTATE_BIT])
        else $error("bad state not flagged");
    chk_bad_state_undecodable_instruction_flag: assert property (
        ev.bad_state && ev.undecodable_instruction_flag_instr && !fault_status_q[`FSC_BADSTATE_BIT]
        |=> !fault_status_q[`FSC_BADSTATE_BIT] && fault_status_q[`FSC_UNDECODABLE_INSTRUCTION_FLAG_BIT])
        else $error("bad state flagged for an undefined instruction");
    chk_bus_address_valid_set_clear: assert property (
        ev.mem_fault_later && !ev.bus_addr_known |=> !fault_status_q[`FSC_BUS_ADDRESS_VALID_BIT])
        else $error("bus address valid survived a later memory fault");
    chk_stack_imprecise_bus_error_flag_set: assert property (
        ev.stacking_err ##0 ev.imprecise_err |=> fault_status_q[`FSC_STK_BIT] && fault_status_q[`FSC_IMPRECISE_BUS_ERROR_FLAG_BIT])
        else $error("stacking or imprecise error not flagged");

    // Register port behaviour.
    chk_word_read_data: assert property (
        req.rd && req.priv && req.size == FSC_SZ_WORD && req.addr == `FSC_FAULT_OFS
        |=> rdata_q == $past(fault_status_q) ##1 rdata_q == 32'h0 || $past(req.rd))
        else $error("word read of fault status wrong");
    chk_usage_half_read: assert property (
        req.rd && req.priv && req.size == FSC_SZ_HALF && req.addr == `FSC_USAGEH_OFS
        |=> rdata_q == {$past(fault_status_q[31:16]), 16'h0000})
        else $error("usage half read wrong");
    chk_unpriv_refused: assert property (
        (req.rd || req.wr) && !req.priv |=> err_q && rdata_q == 32'h0 && $stable(active_q))
        else $error("user mode access not refused");
    chk_active_write: assert property (
        req.wr && req.priv && req.size == FSC_SZ_WORD && req.addr == `FSC_CTRL_OFS
        |=> active_q == $past(req.wdata[1:0]))
        else $error("handler active flags not written");

    // Main scenarios.
    cov_clear_usage_flag: cover property (fault_status_q[`FSC_DIVIDE_ZERO_FLAG_BIT] ##1 !fault_status_q[`FSC_DIVIDE_ZERO_FLAG_BIT]);
    cov_set_beats_clear: cover property (ev.no_coproc && sw_clr[`FSC_MISSING_COPROCESSOR_FLAG_BIT]);
    cov_bus_byte_read: cover property (req.rd && hit_fault && lanes == `FSC_LANES_B1 ##1 rdata_q != 32'h0);
    cov_refused_access: cover property (refused ##1 err_q);

endmodule

// ### verif/fsc_tb.sv
// Holds the self-checking bench of the fault status capture block, with its own reference model.
// Assumes fsc_pkg is compiled first and the block answers one cycle after each request.
`timescale 1ns/1ns

module tb
    import fsc_pkg::*;
;

    ////////////////////////////////////////////////////////////////////////////////
    logic          clk;
    logic          arst_n;
    fsc_bus_req_t  req;
    fsc_events_t   ev;
    logic          div_trap_en;
    logic          misalign_trap_en;
    logic [31:0]   rdata_q;
    logic          err_q;
    logic [31:0]   fault_status_q;
    logic [1:0]    active_q;
    int            bad_count;
    int            tests_run;
    int            cycles;
    logic [1:0]    trap;
    logic [31:0]   m_st;
    logic [1:0]    m_act;
    logic [31:0]   p_rd;
    logic          p_err;
    fsc_events_t   e;
    fsc_bus_req_t  idle;
    logic [11:0]   adr_tab [6];

    // Design under test.
    fsc_fault_status fsc_fault_status_i (
        .clk              (clk),
        .arst_n           (arst_n),
        .req              (req),
        .ev               (ev),
        .div_trap_en      (div_trap_en),
        .misalign_trap_en (misalign_trap_en),
        .rdata_q          (rdata_q),
        .err_q            (err_q),
        .fault_status_q   (fault_status_q),
        .active_q         (active_q)
    );

    // Clock of 100 ns period.
    always #50 clk = ~clk;

    // Cuts a hang short once the cycle ceiling is reached.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count = bad_count + 1;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Compares a word result.
    task automatic cmp_word(string name, logic [31:0] exp, logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compares a one-bit result.
    task automatic cmp_flag(string name, logic exp, logic got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Builds one register port request.
    function automatic fsc_bus_req_t mk(logic [11:0] a, fsc_size_t s, logic w, logic r, logic [31:0] d, logic p);
        fsc_bus_req_t q;
        q.addr  = a;
        q.size  = s;
        q.wr    = w;
        q.rd    = r;
        q.wdata = d;
        q.priv  = p;
        return q;
    endfunction

    // Returns the lanes of a mapped access, bit 4 marking the handler control word; zero when refused.
    function automatic logic [4:0] dec(fsc_bus_req_t r);
        if (!r.priv) return 5'h00;
        if (r.addr == 12'hD28 && r.size == FSC_SZ_WORD) return 5'h0F;
        if (r.addr == 12'hD28 && r.size == FSC_SZ_HALF) return 5'h03;
        if (r.addr == 12'hD28 && r.size == FSC_SZ_BYTE) return 5'h01;
        if (r.addr == 12'hD29 && r.size == FSC_SZ_BYTE) return 5'h02;
        if (r.addr == 12'hD2A && r.size == FSC_SZ_HALF) return 5'h0C;
        if (r.addr == 12'hD24 && r.size == FSC_SZ_WORD) return 5'h1F;
        return 5'h00;
    endfunction

    // Flags that one cycle of fault events raises.
    function automatic logic [31:0] set_of(fsc_events_t v, logic de, logic me);
        logic [31:0] s;
        s     = 32'h0000_0000;
        s[25] = v.divide_zero & de;
        s[24] = (v.misaligned & me) | v.misaligned_multi;
        s[19] = v.no_coproc;
        s[18] = v.bad_return;
        s[17] = v.bad_state & ~v.undecodable_instruction_flag_instr;
        s[16] = v.undecodable_instruction_flag_instr;
        s[15] = v.bus_addr_known;
        s[13] = v.lazy_fp_err;
        s[12] = v.stacking_err;
        s[11] = v.unstacking_err;
        s[10] = v.imprecise_err;
        s[9]  = v.precise_err;
        s[8]  = v.instr_bus_err;
        return s;
    endfunction

    // Drives one cycle, checks the answer to the previous one and advances the model.
    task automatic cyc(fsc_bus_req_t r, fsc_events_t v);
        logic [4:0]  d;
        logic [31:0] lm;
        @(posedge clk);
        req              <= r;
        ev               <= v;
        div_trap_en      <= trap[1];
        misalign_trap_en <= trap[0];
        #1;
        cmp_word("rdata", p_rd, rdata_q);
        cmp_flag("err", p_err, err_q);
        cmp_word("status", m_st, fault_status_q);
        cmp_word("active", {30'h0, m_act}, {30'h0, active_q});
        d     = dec(r);
        lm    = {{8{d[3]}}, {8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
        p_err = (r.rd | r.wr) && d == 5'h00;
        p_rd  = (r.rd && d != 5'h00) ? ((d[4] ? {30'h0, m_act} : m_st) & lm) : 32'h0000_0000;
        if (r.wr && d[4]) m_act = r.wdata[1:0];
        if (r.wr && d != 5'h00 && !d[4]) m_st = m_st & ~(r.wdata & lm);
        m_st = m_st | set_of(v, trap[1], trap[0]);
        if (v.mem_fault_later && !v.bus_addr_known) m_st[15] = 1'b0;
    endtask

    // Reports the end of one test.
    task automatic tend(string name);
        $display("test %s done, mismatches so far %0d", name, bad_count);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        clk = 1'b0; arst_n = 1'b0; cycles = 0; bad_count = 0; tests_run = 0;
        idle = mk(12'h000, FSC_SZ_WORD, 1'b0, 1'b0, 32'h0, 1'b1);
        req = idle; ev = '0; div_trap_en = 1'b0; misalign_trap_en = 1'b0;
        trap = 2'h3; m_st = 32'h0; m_act = 2'h0; p_rd = 32'h0; p_err = 1'b0;
        adr_tab = '{12'hD24, 12'hD28, 12'hD29, 12'hD2A, 12'hD2B, 12'hD2C};
        void'($urandom(84837));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        cmp_word("reset status", 32'h0000_0000, fault_status_q);
        cyc(mk(12'hD28, FSC_SZ_WORD, 1'b0, 1'b1, 32'h0, 1'b1), '0);
        tend("reset");
        // Handler active flags written and read back to back.
        for (int i = 0; i < 4; i++) begin
            cyc(mk(12'hD24, FSC_SZ_WORD, 1'b1, 1'b0, 32'hFFFF_FFF0 | (i ^ 2), 1'b1), '0);
            cyc(mk(12'hD24, FSC_SZ_WORD, 1'b0, 1'b1, 32'h0, 1'b1), '0);
        end
        tend("active");
        // Every fault event alone, traps enabled.
        for (int i = 0; i < 15; i++) cyc(idle, fsc_events_t'(15'h0001 << i));
        cyc(idle, '0);
        cmp_word("all flags", {16'h030F, 8'hBF, 8'h00}, fault_status_q);
        e = '0; e.mem_fault_later = 1'b1;
        cyc(idle, e);
        cyc(idle, '0);
        cmp_flag("address valid", 1'b0, fault_status_q[15]);
        tend("events");
        // Subfield reads, zero writes, then partial and reserved-bit clears.
        cyc(mk(12'hD28, FSC_SZ_BYTE, 1'b0, 1'b1, 32'h0, 1'b1), '0);
        cyc(mk(12'hD28, FSC_SZ_HALF, 1'b0, 1'b1, 32'h0, 1'b1), '0);
        // Bus byte read, its address-valid flag already cleared, after the low byte and low half reads, then the usage half read.
        cyc(mk(12'hD29, FSC_SZ_BYTE, 1'b0, 1'b1, 32'h0, 1'b1), '0);
        cyc(mk(12'hD2A, FSC_SZ_HALF, 1'b0, 1'b1, 32'h0, 1'b1), '0);
        cyc(mk(12'hD28, FSC_SZ_WORD, 1'b1, 1'b0, 32'h0, 1'b1), '0);
        cyc(mk(12'hD2A, FSC_SZ_HALF, 1'b1, 1'b0, 32'h0200_0000, 1'b1), '0);
        cyc(mk(12'hD29, FSC_SZ_BYTE, 1'b1, 1'b0, 32'hFFFF_FFFF, 1'b1), '0);
        cyc(mk(12'hD28, FSC_SZ_WORD, 1'b0, 1'b1, 32'h0, 1'b1), '0);
        tend("subfields");
        // Refused accesses: unprivileged and unmapped.
        cyc(mk(12'hD2A, FSC_SZ_HALF, 1'b1, 1'b0, 32'hFFFF_FFFF, 1'b0), '0);
        cyc(mk(12'hD28, FSC_SZ_WORD, 1'b0, 1'b1, 32'h0, 1'b0), '0);
        cyc(mk(12'hD2C, FSC_SZ_WORD, 1'b0, 1'b1, 32'h0, 1'b1), '0);
        cyc(mk(12'hD29, FSC_SZ_WORD, 1'b1, 1'b0, 32'hFFFF_FFFF, 1'b1), '0);
        tend("refused");
        // Traps off, simultaneous events, and a set beating a clear.
        trap = 2'h0;
        cyc(mk(12'hD28, FSC_SZ_WORD, 1'b1, 1'b0, 32'hFFFF_FFFF, 1'b1), '0);
        e = '0; e.divide_zero = 1'b1; e.misaligned = 1'b1;
        cyc(idle, e);
        cyc(idle, '0);
        cmp_word("traps off", 32'h0000_0000, fault_status_q);
        e = '0; e.misaligned_multi = 1'b1; e.bad_state = 1'b1; e.undecodable_instruction_flag_instr = 1'b1;
        cyc(idle, e);
        cyc(idle, '0);
        cmp_word("multi and state", 32'h0101_0000, fault_status_q);
        trap = 2'h3;
        e = '0; e.divide_zero = 1'b1;
        cyc(mk(12'hD2A, FSC_SZ_HALF, 1'b1, 1'b0, 32'h0200_0000, 1'b1), e);
        tend("traps");
        // Random traffic against the model.
        for (int i = 0; i < 600; i++) begin
            trap = 2'($urandom);
            e    = fsc_events_t'($urandom & $urandom & $urandom);
            cyc(mk(adr_tab[$urandom_range(0, 5)], fsc_size_t'($urandom_range(0, 2)), i[0], ~i[0] & i[1],
                   $urandom, ($urandom_range(0, 7) != 0)), e);
        end
        cyc(idle, '0);
        tend("random");
        stop_test();
    end

endmodule
